// file: design/aer_map.svh
// Register offsets, field positions, reset values and error indices
`ifndef AER_MAP_SVH
`define AER_MAP_SVH

`define AER_COR_STATUS_OFF   12'h110
`define AER_COR_MASK_OFF     12'h114
`define AER_CAP_CTRL_OFF     12'h118
`define AER_HDR_WORD0_OFF    12'h11c
`define AER_HDR_WORD1_OFF    12'h120
`define AER_HDR_WORD2_OFF    12'h124
`define AER_HDR_WORD3_OFF    12'h128

`define AER_BIT_RETRY_TIMER  12
`define AER_BIT_RETRY_ROLL   8
`define AER_BIT_LINK_PKT     7
`define AER_BIT_TRANS_PKT    6
`define AER_BIT_RX_ERR       0
`define AER_COR_WR_MASK      32'h000011c1

`define AER_BIT_CHK_EN       8
`define AER_BIT_CHK_CAP      7
`define AER_BIT_GEN_EN       6
`define AER_BIT_GEN_CAP      5
`define AER_PTR_MSB          4

`define AER_COR_MASK_RST     32'h00000000
`define AER_CAP_CTRL_RST     32'h000000a0
`define AER_HDR_RST          32'h00000000
`define AER_PTR_RST          5'h00
`define AER_END_CRC_INDEX    5'h13

`endif

// file: design/aer_pkg.sv
// Types shared by the error reporting register bank
package aer_pkg;
   typedef enum logic [0:0] {AER_IDLE, AER_RESP} aer_cfg_state_e;
   typedef logic [4:0] aer_cor_vec_t;
endpackage

// file: design/aer_hdr_log.sv
// Header byte assembly and four-word header capture
`timescale 1ns/10ps
`include "aer_map.svh"
module aer_hdr_log
   import aer_pkg::*;
(
   input  wire logic        ref_clk,
   input  wire logic        clear,
   input  wire logic        hdr_byte_valid,
   input  wire logic        hdr_byte_start,
   input  wire logic [7:0]  hdr_byte,
   input  wire logic        capture,
   output logic      [31:0] word0_reg,
   output logic      [31:0] word1_reg,
   output logic      [31:0] word2_reg,
   output logic      [31:0] word3_reg
);

   logic [31:0] stage_reg [0:3];
   logic [3:0]  cnt_reg;
   logic [3:0]  idx;

   assign idx = hdr_byte_start ? 4'h0 : cnt_reg;

   ////////////////////////////////////////////////////////////////////
   always_ff @(posedge ref_clk) begin
      if (clear) begin
         cnt_reg <= 4'h0;
      end else if (hdr_byte_valid) begin
         cnt_reg <= idx + 4'h1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (clear) begin
         for (int i = 0; i < 4; i++) begin
            stage_reg[i] <= `AER_HDR_RST;
         end
      end else if (hdr_byte_valid) begin
         if (hdr_byte_start) begin
            for (int i = 0; i < 4; i++) begin
               stage_reg[i] <= `AER_HDR_RST;
            end
         end
         stage_reg[idx[3:2]][idx[1:0]*8 +: 8] <= hdr_byte;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Cleared on reset
   always_ff @(posedge ref_clk) begin
      if (clear) begin
         word0_reg <= `AER_HDR_RST;
         word1_reg <= `AER_HDR_RST;
         word2_reg <= `AER_HDR_RST;
         word3_reg <= `AER_HDR_RST;
      end else if (capture) begin
         word0_reg <= stage_reg[0];
         word1_reg <= stage_reg[1];
         word2_reg <= stage_reg[2];
         word3_reg <= stage_reg[3];
      end
   end

endmodule

// file: design/aer_mask_ctrl.sv
// Correctable mask, capability/control and header capture registers
//
// Summary of operation
// - Masked correctable error: no status, message, capture or pointer update.
// - Mask bits 12 retry timer and 8 retry rollover, read/write, reset zero.
// - Mask bits 7 link packet and 6 transaction packet, reset unmasked.
// - Mask bit 0 receiver error; one masks, zero reports, reset zero.
// - Unused mask bits read zero and ignore writes.
// - Link reset, global reset or power-on reset restore all defaults.
// - Check enable bit 8 gates received end CRC checking; resets off.
// - Bit 7 always reads one: check capable; writes ignored.
// - Generate enable bit 6 gates end CRC generation; resets off.
// - Bit 5 always reads one: generate capable; writes ignored.
// - Read-only pointer bits 4:0 hold index of first uncorrectable error.
// - Bits 31:9 read zero; register resets to a0 pattern.
// - Each new unmasked error captures its packet header, overwriting.
// - Header words at 11c, 120, 124, 128.
// - Earliest transmitted byte sits in lowest byte lane.
// - Header words read-only, cleared to zero on reset.
// - Status bit set on error at mask position; cleared by writing one.
`timescale 1ns/10ps
`include "aer_map.svh"
module aer_mask_ctrl
   import aer_pkg::*;
(
   input  wire logic        ref_clk,
   input  wire logic        rst_n,
   input  wire logic        link_reset_n,
   input  wire logic        global_reset_input,
   input  wire logic        cfg_req,
   input  wire logic        cfg_wr,
   input  wire logic [11:0] cfg_addr,
   input  wire logic [3:0]  cfg_be,
   input  wire logic [31:0] cfg_wdata,
   output logic             cfg_ack,
   output logic      [31:0] cfg_rdata,
   input  wire logic        rx_err_event,
   input  wire logic        trans_pkt_err_event,
   input  wire logic        link_pkt_err_event,
   input  wire logic        retry_roll_event,
   input  wire logic        retry_timer_event,
   input  wire logic        unc_err_event,
   input  wire logic [4:0]  unc_err_index,
   input  wire logic        unc_ptr_rearm,
   input  wire logic        end_crc_mismatch,
   input  wire logic        hdr_byte_valid,
   input  wire logic        hdr_byte_start,
   input  wire logic [7:0]  hdr_byte,
   output logic             cor_msg_pulse,
   output logic             end_crc_err_pulse,
   output logic             end_crc_check_enable,
   output logic             end_crc_generate_enable
);

   ////////////////////////////////////////////////////////////////////
   // Byte-enable merge, used for the mask write and the status clear
   function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0]  be);
      logic [31:0] res;
      res = old_v;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            res[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return res;
   endfunction

   // Spread the five correctable events onto their register positions
   function automatic logic [31:0] cor_spread(input aer_cor_vec_t v);
      logic [31:0] res;
      res = 32'h00000000;
      res[`AER_BIT_RX_ERR]      = v[0];
      res[`AER_BIT_TRANS_PKT]   = v[1];
      res[`AER_BIT_LINK_PKT]    = v[2];
      res[`AER_BIT_RETRY_ROLL]  = v[3];
      res[`AER_BIT_RETRY_TIMER] = v[4];
      return res;
   endfunction

   ////////////////////////////////////////////////////////////////////
   // Link and global reset pins are asynchronous to ref_clk, so two flops each
   logic link_rst_meta_reg;
   logic link_rst_sync_reg;
   logic glob_rst_meta_reg;
   logic glob_rst_sync_reg;
   logic clear;

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         link_rst_meta_reg <= 1'b1;
         link_rst_sync_reg <= 1'b1;
      end else begin
         link_rst_meta_reg <= ~link_reset_n;
         link_rst_sync_reg <= link_rst_meta_reg;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         glob_rst_meta_reg <= 1'b1;
         glob_rst_sync_reg <= 1'b1;
      end else begin
         glob_rst_meta_reg <= global_reset_input;
         glob_rst_sync_reg <= glob_rst_meta_reg;
      end
   end

   assign clear = ~rst_n | link_rst_sync_reg | glob_rst_sync_reg;

   ////////////////////////////////////////////////////////////////////
   // Register state
   logic [31:0]    correctable_error_mask_reg;
   logic [31:0]    cor_status_reg;
   logic           chk_en_reg;
   logic           gen_en_reg;
   logic [4:0]     first_ptr_reg;
   logic           ptr_valid_reg;
   logic [31:0]    header_capture_word0;
   logic [31:0]    header_capture_word1;
   logic [31:0]    header_capture_word2;
   logic [31:0]    header_capture_word3;
   aer_cfg_state_e cfg_state_reg;
   logic [31:0]    rdata_next;

   logic           wr_take;
   logic [31:0]    cor_raw;
   logic [31:0]    cor_live;
   logic           crc_live;
   logic           unc_live;
   logic           capture;
   logic [31:0]    error_capability_control_rd;

   assign wr_take = cfg_req & cfg_wr & (cfg_state_reg == AER_IDLE);

   assign cor_raw = cor_spread({retry_timer_event, retry_roll_event, link_pkt_err_event,
                                trans_pkt_err_event, rx_err_event});

   assign cor_live = cor_raw & ~correctable_error_mask_reg;

   assign crc_live = end_crc_mismatch & chk_en_reg;

   assign unc_live = unc_err_event | crc_live;

   assign capture = (|cor_live) | unc_live;

   ////////////////////////////////////////////////////////////////////
   // Mask bits writable
   always_ff @(posedge ref_clk) begin
      if (clear) begin
         correctable_error_mask_reg <= `AER_COR_MASK_RST;
      end else if (wr_take && cfg_addr == `AER_COR_MASK_OFF) begin
         correctable_error_mask_reg <= be_merge(correctable_error_mask_reg, cfg_wdata, cfg_be) & `AER_COR_WR_MASK;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (clear) begin
         cor_status_reg <= 32'h00000000;
      end else begin
         if (wr_take && cfg_addr == `AER_COR_STATUS_OFF) begin
            cor_status_reg <= (cor_status_reg & ~be_merge(32'h00000000, cfg_wdata, cfg_be))
                              | cor_live;
         end else begin
            cor_status_reg <= cor_status_reg | cor_live;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Check enable and generate enable
   always_ff @(posedge ref_clk) begin
      if (clear) begin
         chk_en_reg <= 1'b0;
         gen_en_reg <= 1'b0;
      end else if (wr_take && cfg_addr == `AER_CAP_CTRL_OFF) begin
         if (cfg_be[1]) begin
            chk_en_reg <= cfg_wdata[`AER_BIT_CHK_EN];
         end
         if (cfg_be[0]) begin
            gen_en_reg <= cfg_wdata[`AER_BIT_GEN_EN];
         end
      end
   end

   assign end_crc_check_enable    = chk_en_reg;
   assign end_crc_generate_enable = gen_en_reg;

   ////////////////////////////////////////////////////////////////////
   // First uncorrectable index
   // Pointer only rearms when the neighbouring status logic says so
   always_ff @(posedge ref_clk) begin
      if (clear) begin
         first_ptr_reg <= `AER_PTR_RST;
         ptr_valid_reg <= 1'b0;
      end else if (unc_live && (!ptr_valid_reg || unc_ptr_rearm)) begin
         first_ptr_reg <= unc_err_event ? unc_err_index : `AER_END_CRC_INDEX;
         ptr_valid_reg <= 1'b1;
      end else if (unc_ptr_rearm) begin
         ptr_valid_reg <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Reported events leave as registered pulses
   always_ff @(posedge ref_clk) begin
      if (clear) begin
         cor_msg_pulse     <= 1'b0;
         end_crc_err_pulse <= 1'b0;
      end else begin
         cor_msg_pulse     <= |cor_live;
         end_crc_err_pulse <= crc_live;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Header capture storage
   aer_hdr_log u_hdr_log (
      .ref_clk        (ref_clk),
      .clear          (clear),
      .hdr_byte_valid (hdr_byte_valid),
      .hdr_byte_start (hdr_byte_start),
      .hdr_byte       (hdr_byte),
      .capture        (capture),
      .word0_reg      (header_capture_word0),
      .word1_reg      (header_capture_word1),
      .word2_reg      (header_capture_word2),
      .word3_reg      (header_capture_word3)
   );

   ////////////////////////////////////////////////////////////////////
   // Read side
   // Check capable reads one
   always_comb begin
      error_capability_control_rd = 32'h00000000;
      error_capability_control_rd[`AER_BIT_CHK_EN]  = chk_en_reg;
      error_capability_control_rd[`AER_BIT_CHK_CAP] = 1'b1;
      error_capability_control_rd[`AER_BIT_GEN_EN]  = gen_en_reg;
      error_capability_control_rd[`AER_BIT_GEN_CAP] = 1'b1;
      error_capability_control_rd[`AER_PTR_MSB:0]   = first_ptr_reg;
   end

   always_comb begin
      case (cfg_addr)
         `AER_COR_STATUS_OFF: rdata_next = cor_status_reg;
         `AER_COR_MASK_OFF:   rdata_next = correctable_error_mask_reg;
         `AER_CAP_CTRL_OFF:   rdata_next = error_capability_control_rd;
         `AER_HDR_WORD0_OFF:  rdata_next = header_capture_word0;
         `AER_HDR_WORD1_OFF:  rdata_next = header_capture_word1;
         `AER_HDR_WORD2_OFF:  rdata_next = header_capture_word2;
         `AER_HDR_WORD3_OFF:  rdata_next = header_capture_word3;
         default:             rdata_next = 32'h00000000;
      endcase
   end

   ////////////////////////////////////////////////////////////////////
   // One answer per request; no write is taken in the response cycle, keeping one write per access
   always_ff @(posedge ref_clk) begin
      if (clear) begin
         cfg_state_reg <= AER_IDLE;
      end else begin
         case (cfg_state_reg)
            AER_IDLE: begin
               if (cfg_req) begin
                  cfg_state_reg <= AER_RESP;
               end
            end
            AER_RESP: cfg_state_reg <= AER_IDLE;
            default:  cfg_state_reg <= AER_IDLE;
         endcase
      end
   end

   always_ff @(posedge ref_clk) begin
      if (clear) begin
         cfg_rdata <= 32'h00000000;
      end else if (cfg_req && !cfg_wr && cfg_state_reg == AER_IDLE) begin
         cfg_rdata <= rdata_next;
      end
   end

   assign cfg_ack = (cfg_state_reg == AER_RESP);

endmodule

// file: tb/aer_mask_ctrl_properties.sv
// Concurrent checks on the mask, control and header capture register port
`timescale 1ns/10ps
module aer_mask_ctrl_properties (
   input wire logic        ref_clk,
   input wire logic        rst_n,
   input wire logic        link_reset_n,
   input wire logic        global_reset_input,
   input wire logic        cfg_req,
   input wire logic        cfg_wr,
   input wire logic [11:0] cfg_addr,
   input wire logic [3:0]  cfg_be,
   input wire logic [31:0] cfg_wdata,
   input wire logic        cfg_ack,
   input wire logic [31:0] cfg_rdata,
   input wire logic        end_crc_mismatch,
   input wire logic        end_crc_err_pulse,
   input wire logic        end_crc_check_enable,
   input wire logic        end_crc_generate_enable
);
   logic [2:0]  quiet_reg;
   logic [12:0] last_reg;
   logic        rd_mask;
   logic        rd_ctrl;
   ////////////////////////////////////////////////////////////////////////
   // Synced resets clear late, so checks wait for seven quiet edges
   always_ff @(posedge ref_clk) begin
      if (!rst_n || !link_reset_n || global_reset_input)
         quiet_reg <= 3'h0;
      else if (quiet_reg != 3'h7)
         quiet_reg <= quiet_reg + 3'h1;
   end
   always_ff @(posedge ref_clk) begin
      if (cfg_req && !cfg_ack)
         last_reg <= {cfg_wr, cfg_addr};
   end
   assign rd_mask = cfg_ack && (last_reg == {1'b0, 12'h114});
   assign rd_ctrl = cfg_ack && (last_reg == {1'b0, 12'h118});
   default clocking @(posedge ref_clk); endclocking
   default disable iff (quiet_reg != 3'h7);
   ////////////////////////////////////////////////////////////////////////
   a_mask_unused_zero: assert property (rd_mask |-> (cfg_rdata & ~32'h000011c1) == 32'h0)
      else $error("unused mask bits not zero");
   a_check_capable: assert property (rd_ctrl |-> cfg_rdata[7] == 1'b1)
      else $error("check capable bit not one");
   a_gen_capable: assert property (rd_ctrl |-> cfg_rdata[5] == 1'b1)
      else $error("generate capable bit not one");
   a_ctrl_upper_zero: assert property (rd_ctrl |-> cfg_rdata[31:9] == 23'h0)
      else $error("control upper bits not zero");
   a_check_en_read: assert property (rd_ctrl |-> cfg_rdata[8] == end_crc_check_enable)
      else $error("check enable read differs from output");
   a_gen_en_read: assert property (rd_ctrl |-> cfg_rdata[6] == end_crc_generate_enable)
      else $error("generate enable read differs from output");
   a_enable_write: assert property (cfg_ack && last_reg == {1'b1, 12'h118} && $past(cfg_be) == 4'hf
      |-> {end_crc_check_enable, end_crc_generate_enable} == $past({cfg_wdata[8], cfg_wdata[6]}))
      else $error("enable write not taken");
   a_crc_flag_gated: assert property (end_crc_err_pulse |-> $past(end_crc_mismatch && end_crc_check_enable))
      else $error("end crc flag without enabled mismatch");
   a_crc_flag_raised: assert property (end_crc_mismatch && end_crc_check_enable |=> end_crc_err_pulse)
      else $error("enabled mismatch not flagged");
endmodule
bind aer_mask_ctrl aer_mask_ctrl_properties u_props (.ref_clk(ref_clk), .rst_n(rst_n),
   .link_reset_n(link_reset_n), .global_reset_input(global_reset_input), .cfg_req(cfg_req),
   .cfg_wr(cfg_wr), .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_ack(cfg_ack),
   .cfg_rdata(cfg_rdata), .end_crc_mismatch(end_crc_mismatch), .end_crc_err_pulse(end_crc_err_pulse),
   .end_crc_check_enable(end_crc_check_enable), .end_crc_generate_enable(end_crc_generate_enable));

// file: tb/tb.sv
// Self-checking bench for the mask, control and header capture registers
`timescale 1ns/10ps
module tb;
   logic        ref_clk, rst_n, link_reset_n, global_reset_input, cfg_req, cfg_wr, cfg_ack;
   logic        hv, hs, unc_ev, rearm, crc_mm, cor_msg, crc_err, chk_en, gen_en;
   logic [11:0] cfg_addr;
   logic [3:0]  cfg_be;
   logic [31:0] cfg_wdata, cfg_rdata, rd_val;
   logic [7:0]  hb;
   logic [4:0]  ev, unc_idx;
   int          n_fail, checks_done;
   int          pos[5] = '{0, 6, 7, 8, 12};
   aer_mask_ctrl uut (.ref_clk(ref_clk), .rst_n(rst_n), .link_reset_n(link_reset_n),
      .global_reset_input(global_reset_input), .cfg_req(cfg_req), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr),
      .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata),
      .rx_err_event(ev[0]), .trans_pkt_err_event(ev[1]), .link_pkt_err_event(ev[2]),
      .retry_roll_event(ev[3]), .retry_timer_event(ev[4]), .unc_err_event(unc_ev),
      .unc_err_index(unc_idx), .unc_ptr_rearm(rearm), .end_crc_mismatch(crc_mm),
      .hdr_byte_valid(hv), .hdr_byte_start(hs), .hdr_byte(hb), .cor_msg_pulse(cor_msg),
      .end_crc_err_pulse(crc_err), .end_crc_check_enable(chk_en), .end_crc_generate_enable(gen_en));
   initial begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic test_done;
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Request held until ack is sampled, dropped in the ack cycle
   task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge ref_clk);
      cfg_req <= 1'b1;
      cfg_wr <= w;
      cfg_addr <= a;
      cfg_wdata <= d;
      do begin
         @(posedge ref_clk);
         n++;
      end while (cfg_ack !== 1'b1 && n < 8);
      rd_val = cfg_rdata;
      cfg_req <= 1'b0;
      chk({31'h0, cfg_ack}, 32'h1);
   endtask
   task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      chk(rd_val, exp);
   endtask
   task automatic hdr(input logic [7:0] b);
      for (int i = 0; i < 16; i++) begin
         @(posedge ref_clk);
         hv <= 1'b1;
         hs <= (i == 0);
         hb <= b + 8'(i);
      end
      @(posedge ref_clk);
      hv <= 1'b0;
   endtask
   task automatic hchk(input logic [7:0] b);
      for (int w = 0; w < 4; w++)
         rchk(12'h11c + 12'(4 * w), {b + 8'(4 * w + 3), b + 8'(4 * w + 2), b + 8'(4 * w + 1), b + 8'(4 * w)});
   endtask
   // Pulses land one cycle after the event cycle
   task automatic fire(input logic [4:0] e, input logic m, input logic exp_msg, input logic exp_err);
      @(posedge ref_clk);
      ev <= e;
      crc_mm <= m;
      @(posedge ref_clk);
      ev <= 5'h0;
      crc_mm <= 1'b0;
      #1;
      chk({30'h0, cor_msg, crc_err}, {30'h0, exp_msg, exp_err});
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      {rst_n, global_reset_input, cfg_req, cfg_wr, hv, hs, unc_ev, rearm, crc_mm} = '0;
      link_reset_n = 1'b1;
      cfg_addr = 12'h0;
      cfg_be = 4'hf;
      cfg_wdata = 32'h0;
      hb = 8'h0;
      ev = 5'h0;
      unc_idx = 5'h0;
      repeat (16) @(posedge ref_clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge ref_clk);
      rchk(12'h114, 32'h0);
      rchk(12'h118, 32'ha0);
      for (int w = 0; w < 4; w++)
         rchk(12'h11c + 12'(4 * w), 32'h0);
      bus(1'b1, 12'h114, 32'hffffffff);
      rchk(12'h114, 32'h11c1);
      bus(1'b1, 12'h118, 32'h0);
      rchk(12'h118, 32'ha0);
      bus(1'b1, 12'h11c, 32'hffffffff);
      rchk(12'h11c, 32'h0);
      bus(1'b1, 12'h100, 32'hffffffff);
      rchk(12'h100, 32'h0);
      fire(5'h0, 1'b1, 1'b0, 1'b0);
      rchk(12'h118, 32'ha0);
      hdr(8'h40);
      for (int i = 0; i < 5; i++)
         fire(5'(1 << i), 1'b0, 1'b0, 1'b0);
      rchk(12'h110, 32'h0);
      rchk(12'h11c, 32'h0);
      cfg_be <= 4'h2;
      bus(1'b1, 12'h114, 32'h0);
      cfg_be <= 4'hf;
      rchk(12'h114, 32'hc1);
      bus(1'b1, 12'h114, 32'h0);
      // Each class captures a fresh header, overwriting the last
      for (int i = 0; i < 5; i++) begin
         hdr(8'(16 * (i + 1)));
         fire(5'(1 << i), 1'b0, 1'b1, 1'b0);
         hchk(8'(16 * (i + 1)));
         rchk(12'h110, 32'h1 << pos[i]);
         bus(1'b1, 12'h110, 32'hffffffff);
         rchk(12'h110, 32'h0);
      end
      bus(1'b1, 12'h118, 32'hffffffff);
      rchk(12'h118, 32'h1e0);
      chk({30'h0, chk_en, gen_en}, 32'h3);
      hdr(8'h80);
      fire(5'h0, 1'b1, 1'b0, 1'b1);
      rchk(12'h118, 32'h1f3);
      hchk(8'h80);
      @(posedge ref_clk);
      unc_ev <= 1'b1;
      unc_idx <= 5'h04;
      @(posedge ref_clk);
      unc_ev <= 1'b0;
      rchk(12'h118, 32'h1f3);
      @(posedge ref_clk);
      rearm <= 1'b1;
      @(posedge ref_clk);
      rearm <= 1'b0;
      unc_ev <= 1'b1;
      @(posedge ref_clk);
      unc_ev <= 1'b0;
      rchk(12'h118, 32'h1e4);
      // Global reset pin, link reset pin, then power-on reset mid-run
      for (int k = 0; k < 3; k++) begin
         if (k == 0)
            global_reset_input <= 1'b1;
         else if (k == 1)
            link_reset_n <= 1'b0;
         else
            rst_n <= 1'b0;
         repeat (4) @(posedge ref_clk);
         global_reset_input <= 1'b0;
         link_reset_n <= 1'b1;
         rst_n <= 1'b1;
         repeat (4) @(posedge ref_clk);
         rchk(12'h114, 32'h0);
         rchk(12'h118, 32'ha0);
         rchk(12'h11c, 32'h0);
         bus(1'b1, 12'h114, 32'h11c1);
         bus(1'b1, 12'h118, 32'h140);
         hdr(8'h20);
         fire(5'h0, 1'b1, 1'b0, 1'b1);
         rchk(12'h11c, 32'h23222120);
      end
      test_done;
   end
   initial begin
      repeat (20000) @(posedge ref_clk);
      n_fail++;
      test_done;
   end
endmodule
